//--- logic/tcisp_regs.vh
`ifndef TCISP_REGS_VH
`define TCISP_REGS_VH
// ---------------------------------------------------------------
// Bus addresses (write byte values)
// ---------------------------------------------------------------
`define TCISP_ADDR_PRIMARY  8'hba
`define TCISP_ADDR_ALTERN   8'h28
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TCISP_CLK_KHZ       250000
`define TCISP_MAX_KBPS      400
`define TCISP_CYC_PER_BIT   (`TCISP_CLK_KHZ / `TCISP_MAX_KBPS)
`define TCISP_STRAP_WAIT    3'h3
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TCISP_PTR_RST       16'h0000
`define TCISP_BYTE_RST      8'h00
`define TCISP_PIN_IDLE      3'h3
// ---------------------------------------------------------------
// Byte kinds within a frame
// ---------------------------------------------------------------
`define TCISP_KIND_ADDR     2'h0
`define TCISP_KIND_PTRH     2'h1
`define TCISP_KIND_PTRL     2'h2
`define TCISP_KIND_DATA     2'h3
`endif

//--- logic/tcisp_slave.v
`timescale 1ns/1ps
`include "tcisp_regs.vh"
// Behaviour
// - Target only; never drives a start, only answers the host.
// - Answers 0xBA/0xBB or 0x28/0x29, chosen at initialization.
// - Address pair picked from interrupt pin level at reset release.
// - Start is SDA falling while SCL high; detected before address byte.
// - Matching address byte is acknowledged by pulling SDA low on clock nine.
// - Unmatched address gets no acknowledge; idle until next start.
// - Each byte is eight data bits then one acknowledge bit.
// - SDA sampled while SCL high; changed only while SCL low.
// - Stop is SDA rising while SCL high; returns to idle.
// - Write: address with direction 0, 16-bit pointer, data; all acknowledged.
// - Pointer increments by one after every written data byte.
// - Sequential write continues until a stop.
// - After read address acknowledged, bytes are sent from the pointer.
// - Each host acknowledge fetches the byte at the next address.
// - Host not-acknowledge makes the device release SDA and stop.
module tcisp_slave (
	input  wire        CLK_IN,
	input  wire        RST_IN,
	input  wire        SCL_IN,
	input  wire        SDA_IN,
	output wire        SDA_OUT,
	output reg         SDA_OE_OUT,
	input  wire        INT_PIN_IN,
	output reg         ADDR_SEL_OUT,
	output reg  [15:0] REG_ADDR_OUT,
	output reg  [7:0]  REG_WDATA_OUT,
	output reg         REG_WR_OUT,
	output reg         REG_RD_OUT,
	input  wire [7:0]  REG_RDATA_IN,
	output wire        BUSY_OUT
);

	// -----------------------------------------------------------
	// States
	// -----------------------------------------------------------
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_RECV = 5'h02;
	localparam [4:0] S_ACK  = 5'h04;
	localparam [4:0] S_SEND = 5'h08;
	localparam [4:0] S_HACK = 5'h10;

	// -----------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------
	// Synchroniser idle levels, order {strap, SDA, SCL}
	localparam [2:0] PIN_IDLE = `TCISP_PIN_IDLE;

	reg         scl_d;
	reg         sda_d;
	reg  [4:0]  state;
	reg  [3:0]  bit_cnt;
	reg  [7:0]  rx_byte;
	reg  [7:0]  tx_byte;
	reg  [1:0]  kind;
	reg         rw;
	reg  [15:0] ptr;
	reg         rd_dly;
	reg  [2:0]  strap_cnt;
	reg         strap_done;

	wire [2:0]  pin_raw;
	wire [2:0]  pin_sync;
	wire        scl_s;
	wire        sda_s;
	wire        scl_rise;
	wire        scl_fall;
	wire        start_det;
	wire        stop_det;
	wire [7:0]  own_addr;
	wire        addr_hit;

	// -----------------------------------------------------------
	// Bus outputs
	// -----------------------------------------------------------
	// Open drain: only ever pulls low, never drives SDA high
	assign SDA_OUT  = 1'b0;
	assign BUSY_OUT = ~state[0];

	// -----------------------------------------------------------
	// Pin synchronisers and edge detection
	// -----------------------------------------------------------
	assign pin_raw = {INT_PIN_IN, SDA_IN, SCL_IN};

	// One two-stage chain per pin; only the second stage is read
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			reg meta;
			reg stab;
			always @(posedge CLK_IN or posedge RST_IN) begin
				if (RST_IN) begin
					meta <= PIN_IDLE[g];
					stab <= PIN_IDLE[g];
				end else begin
					meta <= pin_raw[g];
					stab <= meta;
				end
			end
			assign pin_sync[g] = stab;
		end
	endgenerate

	// Reset to the idle level so no false edge follows reset
	always @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_s     = pin_sync[0];
	assign sda_s     = pin_sync[1];
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	// Qualified by SCL high in both samples so an SDA move on a clock edge
	// is not mistaken for a start or stop
	assign start_det = scl_s & scl_d & ~sda_s & sda_d;
	assign stop_det  = scl_s & scl_d & sda_s & ~sda_d;

	// -----------------------------------------------------------
	// Address strap, caught once after reset release
	// -----------------------------------------------------------
	// Read once per reset; moving the pin later has no effect
	// Waits for the synchroniser to fill so the strap is a settled level
	always @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			strap_cnt    <= 3'h0;
			strap_done   <= 1'b0;
			ADDR_SEL_OUT <= 1'b0;
		end else if (!strap_done) begin
			if (strap_cnt == `TCISP_STRAP_WAIT) begin
				strap_done   <= 1'b1;
				ADDR_SEL_OUT <= pin_sync[2];
			end else begin
				strap_cnt <= strap_cnt + 3'h1;
			end
		end
	end

	// -----------------------------------------------------------
	// Address match
	// -----------------------------------------------------------
	// Direction bit is left out; it picks the phase, not the target
	assign own_addr = ADDR_SEL_OUT ? `TCISP_ADDR_ALTERN : `TCISP_ADDR_PRIMARY;
	assign addr_hit = (rx_byte[7:1] == own_addr[7:1]);

	// -----------------------------------------------------------
	// Bit and byte engine
	// -----------------------------------------------------------
	// No clock stretching: the host must leave SCL low for a few cycles
	always @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state         <= S_IDLE;
			bit_cnt       <= 4'h0;
			rx_byte       <= `TCISP_BYTE_RST;
			tx_byte       <= `TCISP_BYTE_RST;
			kind          <= `TCISP_KIND_ADDR;
			rw            <= 1'b0;
			ptr           <= `TCISP_PTR_RST;
			SDA_OE_OUT    <= 1'b0;
			REG_ADDR_OUT  <= `TCISP_PTR_RST;
			REG_WDATA_OUT <= `TCISP_BYTE_RST;
			REG_WR_OUT    <= 1'b0;
			REG_RD_OUT    <= 1'b0;
			rd_dly        <= 1'b0;
		end else begin
			REG_WR_OUT <= 1'b0;
			REG_RD_OUT <= 1'b0;
			rd_dly     <= REG_RD_OUT;
			// Read data is taken one cycle after the strobe
			if (rd_dly)
				tx_byte <= REG_RDATA_IN;
			// Start and stop are tested before the state case, after the strap check, so they cut any byte short
			if (!strap_done) begin
				// No bus activity until the address is known
				state      <= S_IDLE;
				SDA_OE_OUT <= 1'b0;
			end else if (start_det) begin
				// Repeated start keeps the pointer for the read phase
				state      <= S_RECV;
				bit_cnt    <= 4'h0;
				kind       <= `TCISP_KIND_ADDR;
				SDA_OE_OUT <= 1'b0;
			end else if (stop_det) begin
				state      <= S_IDLE;
				SDA_OE_OUT <= 1'b0;
			end else begin
				case (state)
				S_IDLE: begin
					// Never drives the bus on its own
					SDA_OE_OUT <= 1'b0;
				end
				// A frame cut after one pointer byte writes nothing
				S_RECV: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						rx_byte <= {rx_byte[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						case (kind)
						`TCISP_KIND_ADDR: begin
							if (addr_hit) begin
								rw         <= rx_byte[0];
								kind       <= `TCISP_KIND_PTRH;
								SDA_OE_OUT <= 1'b1;
								state      <= S_ACK;
								if (rx_byte[0]) begin
									REG_ADDR_OUT <= ptr;
									REG_RD_OUT   <= 1'b1;
								end
							end else begin
								state <= S_IDLE;
							end
						end
						`TCISP_KIND_PTRH: begin
							ptr[15:8]  <= rx_byte;
							kind       <= `TCISP_KIND_PTRL;
							SDA_OE_OUT <= 1'b1;
							state      <= S_ACK;
						end
						`TCISP_KIND_PTRL: begin
							ptr[7:0]   <= rx_byte;
							kind       <= `TCISP_KIND_DATA;
							SDA_OE_OUT <= 1'b1;
							state      <= S_ACK;
						end
						`TCISP_KIND_DATA: begin
							REG_ADDR_OUT  <= ptr;
							REG_WDATA_OUT <= rx_byte;
							REG_WR_OUT    <= 1'b1;
							ptr           <= ptr + 16'h0001;
							SDA_OE_OUT    <= 1'b1;
							state         <= S_ACK;
						end
						default: begin
							state <= S_IDLE;
						end
						endcase
					end
				end
				// Read fetch takes two cycles; SCL high on clock nine must outlast it
				S_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							// First data bit goes out in the same low phase
							SDA_OE_OUT <= ~tx_byte[7];
							bit_cnt    <= 4'h1;
							state      <= S_SEND;
						end else begin
							SDA_OE_OUT <= 1'b0;
							state      <= S_RECV;
						end
					end
				end
				S_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							// Let go so the host can answer on clock nine
							SDA_OE_OUT <= 1'b0;
							state      <= S_HACK;
						end else begin
							tx_byte    <= {tx_byte[6:0], 1'b0};
							SDA_OE_OUT <= ~tx_byte[6];
							bit_cnt    <= bit_cnt + 4'h1;
						end
					end
				end
				// Host acknowledge prefetches; the pointer stays on the last byte read
				S_HACK: begin
					if (scl_rise) begin
						if (!sda_s) begin
							ptr          <= ptr + 16'h0001;
							REG_ADDR_OUT <= ptr + 16'h0001;
							REG_RD_OUT   <= 1'b1;
						end else begin
							// Not-acknowledge: stay off the bus until the next start
							state <= S_IDLE;
						end
					end else if (scl_fall) begin
						SDA_OE_OUT <= ~tx_byte[7];
						bit_cnt    <= 4'h1;
						state      <= S_SEND;
					end
				end
				default: begin
					state      <= S_IDLE;
					SDA_OE_OUT <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule // tcisp_slave

//--- verif/tcisp_chk_sva.sv
`timescale 1ns/1ps
module tcisp_chk (
	input wire        CLK_IN,
	input wire        RST_IN,
	input wire        SCL_IN,
	input wire        SDA_IN,
	input wire        SDA_OUT,
	input wire        SDA_OE_OUT,
	input wire        REG_WR_OUT,
	input wire        REG_RD_OUT,
	input wire [15:0] REG_ADDR_OUT,
	input wire        BUSY_OUT
);
	// Last write address of the frame, forgotten while the port is idle
	reg [15:0] last_wa;
	reg        wr_seen;
	always @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			last_wa <= 16'h0000;
			wr_seen <= 1'b0;
		end else if (!BUSY_OUT) begin
			wr_seen <= 1'b0;
		end else if (REG_WR_OUT) begin
			last_wa <= REG_ADDR_OUT;
			wr_seen <= 1'b1;
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	chk_sda_zero: assert property (!SDA_OUT)
		else $error("sda drive value high");
	chk_idle_rel: assert property (!BUSY_OUT |-> !SDA_OE_OUT)
		else $error("sda driven while idle");
	chk_wr_pulse: assert property (REG_WR_OUT |=> !REG_WR_OUT)
		else $error("write strobe too long");
	chk_rd_pulse: assert property (REG_RD_OUT |=> !REG_RD_OUT)
		else $error("read strobe too long");
	chk_wr_ack: assert property (REG_WR_OUT |-> SDA_OE_OUT)
		else $error("write byte not acknowledged");
	chk_ptr_step: assert property (REG_WR_OUT && wr_seen |-> REG_ADDR_OUT == last_wa + 16'h0001)
		else $error("pointer not stepped by one");
	chk_oe_scl: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
		else $error("sda moved while scl high");
	chk_stop_idle: assert property ($rose(SDA_IN) && SCL_IN && $past(SCL_IN) |-> ##[1:8] !BUSY_OUT)
		else $error("no idle after stop");
	chk_start_busy: assert property ($fell(SDA_IN) && SCL_IN && $past(SCL_IN) |-> ##[1:8] BUSY_OUT)
		else $error("start not seen");
	chk_one_strobe: assert property (!(REG_WR_OUT && REG_RD_OUT))
		else $error("read and write together");
	cover property (REG_WR_OUT);
	cover property (REG_RD_OUT);
	cover property ($fell(SDA_OE_OUT));
endmodule // tcisp_chk
bind tcisp_slave tcisp_chk i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .REG_WR_OUT(REG_WR_OUT),
	.REG_RD_OUT(REG_RD_OUT), .REG_ADDR_OUT(REG_ADDR_OUT), .BUSY_OUT(BUSY_OUT));

//--- verif/tcisp_host.sv
`timescale 1ns/1ps
module tcisp_host (
	input  wire sda_in,
	output reg  scl_out,
	output reg  sda_low_out
);
	reg     r;
	integer i;
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// ----
	// Bus phases, 160 ns bit in 40 ns steps
	// ----
	task start; begin
		#40 sda_low_out = 1'b0;
		#40 scl_out = 1'b1;
		#40 sda_low_out = 1'b1;
		#40 scl_out = 1'b0;
	end endtask
	task stop; begin
		#40 sda_low_out = 1'b1;
		#40 scl_out = 1'b1;
		#40 sda_low_out = 1'b0;
		#40;
	end endtask
	task bit_io(input b, output s); begin
		#40 sda_low_out = ~b;
		#40 scl_out = 1'b1;
		#40 s = sda_in;
		#40 scl_out = 1'b0;
	end endtask
	task wbyte(input [7:0] d, output ack); begin
		for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	end endtask
	task rbyte(input last, output [7:0] d); begin
		for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
		bit_io(last, r);
	end endtask
endmodule // tcisp_host

//--- verif/test_touch_ctrl_i2c_slave_port.sv
`timescale 1ns/1ps
module test_touch_ctrl_i2c_slave_port;
	reg         clk = 1'b0, rst = 1'b1, int_pin = 1'b0, ack;
	reg  [7:0]  rdata = 8'h00, d, mem [0:65535], model [0:65535];
	reg  [15:0] p, q;
	reg  [31:0] lfsr = 32'hdadd3e80;
	reg  [23:0] wq [$];
	wire        scl, sda_low, oe, sda_o, sel, wr, rd, busy;
	wire [15:0] addr;
	wire [7:0]  wdata;
	wire        sda = ~(sda_low | oe);
	integer     miscompares = 0, tests_run = 0, i;
	always #2 clk = ~clk;
	tcisp_slave i_tcisp_slave (.CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_o), .SDA_OE_OUT(oe), .INT_PIN_IN(int_pin), .ADDR_SEL_OUT(sel),
		.REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdata), .REG_WR_OUT(wr), .REG_RD_OUT(rd),
		.REG_RDATA_IN(rdata), .BUSY_OUT(busy));
	tcisp_host i_tcisp_host (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
	// ----
	// Register stub and checks
	// ----
	always @(posedge clk) begin
		if (rd) rdata <= #1 mem[addr];
		if (wr) mem[addr] <= wdata;
		if (wr) cmp({addr, wdata}, wq.size() ? wq.pop_front() : 24'hxxxxxx);
	end
	task cmp(input [23:0] g, input [23:0] e); begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	end endtask
	function [31:0] lfsr_next(input [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task wrap_up; begin
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	end endtask
	task boot(input s); begin
		@(posedge clk) #1 rst = 1'b1;
		int_pin = s;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (12) @(posedge clk);
		#1 cmp(sel, s);
		lfsr = lfsr_next(lfsr);
		p = {1'b0, lfsr[14:0]};
	end endtask
	task addr_ptr(input [7:0] a, input ok); begin
		i_tcisp_host.start;
		i_tcisp_host.wbyte(a, ack);
		cmp(ack, ok);
		i_tcisp_host.wbyte(p[15:8], ack);
		cmp(ack, ok);
		i_tcisp_host.wbyte(p[7:0], ack);
		cmp(ack, ok);
	end endtask
	task wr_frame(input [7:0] a, input integer n, input ok); begin
		addr_ptr(a, ok);
		for (i = 0; i < n; i = i + 1) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr[7:0];
			q = p + i;
			if (ok) model[q] = d;
			if (ok) wq.push_back({q, d});
			i_tcisp_host.wbyte(d, ack);
			cmp(ack, ok);
		end
		i_tcisp_host.stop;
		cmp(busy, 1'b0);
		cmp(24'(wq.size()), 24'h000000);
	end endtask
	task rd_frame(input [7:0] a, input integer n); begin
		addr_ptr(a, 1'b1);
		i_tcisp_host.start;
		i_tcisp_host.wbyte(a | 8'h01, ack);
		cmp(ack, 1'b1);
		for (i = 0; i < n; i = i + 1) begin
			i_tcisp_host.rbyte(i == n - 1, d);
			q = p + i;
			cmp(d, model[q]);
		end
		cmp(oe, 1'b0);
		i_tcisp_host.stop;
	end endtask
	initial begin
		// Tests need about 50 us; three times that before giving up
		#150000;
		miscompares = miscompares + 1;
		wrap_up;
	end
	initial begin
		boot(1'b0);
		wr_frame(8'hba, 3, 1'b1);
		rd_frame(8'hba, 3);
		wr_frame(8'h28, 2, 1'b0);
		boot(1'b1);
		wr_frame(8'h28, 2, 1'b1);
		rd_frame(8'h28, 2);
		wr_frame(8'hba, 1, 1'b0);
		wrap_up;
	end
endmodule // test_touch_ctrl_i2c_slave_port
